// [design/odl_defines.svh]
// Purpose: Constants shared by both ends of the octal DAC serial loader
// Assumes: Host runs on a 200 MHz system clock
// Notes: Times in ns; cycle counts are derived and round up
`ifndef ODL_DEFINES_SVH
`define ODL_DEFINES_SVH

`define ODL_WORD_BITS 12
`define ODL_ADDR_BITS 4
`define ODL_DATA_BITS 8
`define ODL_NUM_CH 8
`define ODL_ADDR_MSB 11
`define ODL_ADDR_LSB 8
`define ODL_DATA_MSB 7
`define ODL_MIDSCALE 8'h80
`define ODL_ADDR_FIRST_CH 4'h1
`define ODL_FIFO_DEPTH 8
`define ODL_FIFO_PTR_BITS 3
`define ODL_FIFO_CNT_BITS 4

`define ODL_CLK_PERIOD_NS 5
`define ODL_SCLK_HALF_NS 20
`define ODL_STROBE_NS 20
`define ODL_SCLK_HALF_CYC \
    ((`ODL_SCLK_HALF_NS + `ODL_CLK_PERIOD_NS - 1) / `ODL_CLK_PERIOD_NS)
`define ODL_STROBE_CYC \
    ((`ODL_STROBE_NS + `ODL_CLK_PERIOD_NS - 1) / `ODL_CLK_PERIOD_NS)
`define ODL_TIMER_BITS 8
`define ODL_BITCNT_BITS 4

`endif

// [design/odl_pkg.sv]
// Purpose: Types for the octal DAC serial loader
// Assumes: odl_defines.svh supplies the widths
// Notes: Nothing here is imported; use odl_pkg::name
`include "odl_defines.svh"

package odl_pkg;
    typedef logic [`ODL_WORD_BITS-1:0] odl_word_t;
    typedef logic [`ODL_DATA_BITS-1:0] odl_code_t;
    typedef logic [`ODL_ADDR_BITS-1:0] odl_addr_t;

    typedef enum logic [2:0] {
        ODL_IDLE = 3'b000,
        ODL_PRESET = 3'b001,
        ODL_SHIFT_LO = 3'b010,
        ODL_SHIFT_HI = 3'b011,
        ODL_LOAD = 3'b100
    } odl_host_state_e;
endpackage : odl_pkg

// [design/odl_if.sv]
// Purpose: Serial link between host controller and octal DAC loader
// Assumes: Host drives clock, data, strobe and preset
// Notes: Serial clock and load strobe are the device's only clocks
interface odl_if;
    logic serial_clock;
    logic serial_data_in;
    logic load_strobe;
    logic midscale_preset_n;
    logic serial_data_out;

    modport host (
        output serial_clock,
        output serial_data_in,
        output load_strobe,
        output midscale_preset_n,
        input serial_data_out
    );

    modport dev (
        input serial_clock,
        input serial_data_in,
        input load_strobe,
        input midscale_preset_n,
        output serial_data_out
    );
endinterface : odl_if

// [design/odl_fifo.sv]
// Purpose: Word FIFO ahead of the serial shifter
// Assumes: Both sides on MCLK
// Notes: in_ready is registered so it can leave the top directly
`include "odl_defines.svh"

module odl_fifo #(
    parameter int WIDTH = `ODL_WORD_BITS,
    parameter int DEPTH = `ODL_FIFO_DEPTH,
    parameter int PTR_BITS = `ODL_FIFO_PTR_BITS,
    parameter int CNT_BITS = `ODL_FIFO_CNT_BITS
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PTR_BITS-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [CNT_BITS-1:0] cnt_r, cnt_nxt;
    logic ready_r, ready_nxt;
    logic push, pop;

    assign push = ce && in_valid && ready_r;
    assign pop = ce && out_valid && out_ready;
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rd_r];
    // Kept as its own flop so the top's ready needs no gate after it
    assign in_ready = ready_r;

    always_comb begin
        wr_nxt = push ? PTR_BITS'(wr_r + 1'b1) : wr_r;
        rd_nxt = pop ? PTR_BITS'(rd_r + 1'b1) : rd_r;
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = CNT_BITS'(cnt_r + 1'b1);
        end else if (pop && !push) begin
            cnt_nxt = CNT_BITS'(cnt_r - 1'b1);
        end
        ready_nxt = (cnt_nxt != CNT_BITS'(DEPTH));
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
            ready_r <= 1'b1;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
            ready_r <= ready_nxt;
        end
    end

    // Storage has no reset: contents are only read once counted valid
    for (genvar e = 0; e < DEPTH; e++) begin : g_entry
        always_ff @(posedge clk) begin
            if (push && wr_r == PTR_BITS'(e)) begin
                mem_r[e] <= in_data;
            end
        end
    end
endmodule : odl_fifo

// [design/odl_dev.sv]
// Purpose: Device end: 12-stage shifter and eight channel code registers
// Assumes: Host keeps strobe and serial clock apart in time
// Notes: Serial clock and load strobe are the only clocks here
`include "odl_defines.svh"

// Overview of operation
// - Shift in on rising clock, strobe low
// - First four bits are address, MSB first
// - Eight data bits follow, MSB first
// - Strobe high loads data to addressed channel
// - Strobe clocks every channel register; only the selected one takes data
// - Last stage drives serial data out
// - Addresses 1 to 8 select channels A-H
// - Addresses 0 and 9-15 change nothing
// - Preset low forces all channels to 80h
// - No clock, no strobe: everything holds
// - Host releases preset with strobe low
// - Host gives no rising clock during strobe
// - Host strobes only after twelve bits
// - Cascades use no-op addresses for others
module odl_dev (
    // Serial link
    odl_if.dev link,
    // Channel codes, channel A in the low byte
    output logic [`ODL_NUM_CH*`ODL_DATA_BITS-1:0] CHANNEL_CODES
);
    odl_pkg::odl_word_t shift_r, shift_nxt;
    odl_pkg::odl_addr_t addr;
    odl_pkg::odl_code_t data;
    logic shift_en;

    // Preset wins over shifting; strobe high blocks it too
    assign shift_en = !link.load_strobe && link.midscale_preset_n;

    always_comb begin
        shift_nxt = shift_en ?
            {shift_r[`ODL_WORD_BITS-2:0], link.serial_data_in} :
            shift_r;
    end

    // No reset: contents are unknown until twelve bits are in
    always_ff @(posedge link.serial_clock) begin
        shift_r <= shift_nxt;
    end

    // Cascade and readback tap
    assign link.serial_data_out = shift_r[`ODL_WORD_BITS-1];

    assign addr = shift_r[`ODL_ADDR_MSB:`ODL_ADDR_LSB];
    assign data = shift_r[`ODL_DATA_MSB:0];

    // Strobe edge is each register's clock, steered by the address decode
    for (genvar ch = 0; ch < `ODL_NUM_CH; ch++) begin : g_ch
        odl_pkg::odl_code_t code_r, code_nxt;
        logic sel;

        assign sel = (addr ==
            odl_pkg::odl_addr_t'(`ODL_ADDR_FIRST_CH + ch));

        always_comb begin
            code_nxt = sel ? data : code_r;
        end

        always_ff @(posedge link.load_strobe
                or negedge link.midscale_preset_n) begin
            if (!link.midscale_preset_n) begin
                code_r <= `ODL_MIDSCALE;
            end else begin
                code_r <= code_nxt;
            end
        end

        assign CHANNEL_CODES[ch*`ODL_DATA_BITS +: `ODL_DATA_BITS] = code_r;
    end
endmodule : odl_dev

// [design/odl_host.sv]
// Purpose: Host end: drains a word FIFO onto the serial link
// Assumes: MCLK at 200 MHz; serial clock made by dividing MCLK
// Notes: Each word ends with one load strobe; readback is captured
`include "odl_defines.svh"

module odl_host (
    // Clock, reset, enable
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CE,
    // Words to send: address in [11:8], code in [7:0]
    input wire logic [`ODL_WORD_BITS-1:0] WORD_DATA,
    input wire logic WORD_VALID,
    output logic WORD_READY,
    // Preset request, level
    input wire logic PRESET_REQ,
    // Status and readback
    output logic BUSY,
    output logic [`ODL_WORD_BITS-1:0] READBACK_WORD,
    output logic READBACK_VALID,
    // Serial link
    odl_if.host link
);
    odl_pkg::odl_host_state_e state_r, state_nxt;
    odl_pkg::odl_word_t shreg_r, shreg_nxt, rb_r, rb_nxt;
    logic [`ODL_TIMER_BITS-1:0] timer_r, timer_nxt;
    logic [`ODL_BITCNT_BITS-1:0] bitcnt_r, bitcnt_nxt;
    logic sclk_r, sclk_nxt, sdi_r, sdi_nxt, stb_r, stb_nxt;
    logic pre_n_r, pre_n_nxt, rbv_r, rbv_nxt, busy_nxt, busy_r;
    logic sdo_s1_r, sdo_s2_r;
    logic [`ODL_WORD_BITS-1:0] fifo_data;
    logic fifo_valid, fifo_ready, half_done, stb_done;

    odl_fifo u_fifo (
        .clk(MCLK),
        .rst(RST),
        .ce(CE),
        .in_data(WORD_DATA),
        .in_valid(WORD_VALID),
        .in_ready(WORD_READY),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready)
    );

    // Readback comes from the other domain
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            sdo_s1_r <= 1'b0;
            sdo_s2_r <= 1'b0;
        end else if (CE) begin
            sdo_s1_r <= link.serial_data_out;
            sdo_s2_r <= sdo_s1_r;
        end
    end

    assign fifo_ready = (state_r == odl_pkg::ODL_IDLE) && !PRESET_REQ;
    assign half_done = (timer_r ==
        `ODL_TIMER_BITS'(`ODL_SCLK_HALF_CYC - 1));
    assign stb_done = (timer_r == `ODL_TIMER_BITS'(`ODL_STROBE_CYC - 1));

    always_comb begin
        state_nxt = state_r;
        shreg_nxt = shreg_r;
        rb_nxt = rb_r;
        timer_nxt = `ODL_TIMER_BITS'(timer_r + 1'b1);
        bitcnt_nxt = bitcnt_r;
        sclk_nxt = sclk_r;
        sdi_nxt = sdi_r;
        stb_nxt = stb_r;
        pre_n_nxt = pre_n_r;
        rbv_nxt = 1'b0;
        case (state_r)
            odl_pkg::ODL_IDLE: begin
                timer_nxt = '0;
                if (PRESET_REQ) begin
                    pre_n_nxt = 1'b0;
                    state_nxt = odl_pkg::ODL_PRESET;
                end else if (fifo_valid) begin
                    shreg_nxt = fifo_data;
                    sdi_nxt = fifo_data[`ODL_WORD_BITS-1];
                    bitcnt_nxt = '0;
                    state_nxt = odl_pkg::ODL_SHIFT_LO;
                end
            end
            odl_pkg::ODL_PRESET: begin
                // Strobe is low here, so every channel keeps midscale
                if (!PRESET_REQ) begin
                    pre_n_nxt = 1'b1;
                    state_nxt = odl_pkg::ODL_IDLE;
                end
            end
            odl_pkg::ODL_SHIFT_LO: begin
                if (half_done) begin
                    timer_nxt = '0;
                    rb_nxt = {rb_r[`ODL_WORD_BITS-2:0], sdo_s2_r};
                    sclk_nxt = 1'b1;
                    state_nxt = odl_pkg::ODL_SHIFT_HI;
                end
            end
            odl_pkg::ODL_SHIFT_HI: begin
                if (half_done) begin
                    timer_nxt = '0;
                    sclk_nxt = 1'b0;
                    shreg_nxt = {shreg_r[`ODL_WORD_BITS-2:0], 1'b0};
                    sdi_nxt = shreg_r[`ODL_WORD_BITS-2];
                    bitcnt_nxt = `ODL_BITCNT_BITS'(bitcnt_r + 1'b1);
                    if (bitcnt_r ==
                            `ODL_BITCNT_BITS'(`ODL_WORD_BITS - 1)) begin
                        // Strobe only once all twelve bits are in
                        stb_nxt = 1'b1;
                        state_nxt = odl_pkg::ODL_LOAD;
                    end else begin
                        state_nxt = odl_pkg::ODL_SHIFT_LO;
                    end
                end
            end
            odl_pkg::ODL_LOAD: begin
                // Serial clock stays low for the whole strobe
                if (stb_done) begin
                    stb_nxt = 1'b0;
                    rbv_nxt = 1'b1;
                    state_nxt = odl_pkg::ODL_IDLE;
                end
            end
            default: begin
                state_nxt = odl_pkg::ODL_IDLE;
            end
        endcase
        busy_nxt = (state_nxt != odl_pkg::ODL_IDLE);
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state_r <= odl_pkg::ODL_IDLE;
            shreg_r <= '0;
            rb_r <= '0;
            timer_r <= '0;
            bitcnt_r <= '0;
            sclk_r <= 1'b0;
            sdi_r <= 1'b0;
            stb_r <= 1'b0;
            pre_n_r <= 1'b1;
            rbv_r <= 1'b0;
            busy_r <= 1'b0;
        end else if (CE) begin
            state_r <= state_nxt;
            shreg_r <= shreg_nxt;
            rb_r <= rb_nxt;
            timer_r <= timer_nxt;
            bitcnt_r <= bitcnt_nxt;
            sclk_r <= sclk_nxt;
            sdi_r <= sdi_nxt;
            stb_r <= stb_nxt;
            pre_n_r <= pre_n_nxt;
            rbv_r <= rbv_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign link.serial_clock = sclk_r;
    assign link.serial_data_in = sdi_r;
    assign link.load_strobe = stb_r;
    assign link.midscale_preset_n = pre_n_r;
    assign READBACK_WORD = rb_r;
    assign READBACK_VALID = rbv_r;
    assign BUSY = busy_r;
endmodule : odl_host

// [tb/odl_checker.sv]
// Purpose: Timing checks on the serial link between host and device
// Assumes: Host half period and strobe width are 4 MCLK cycles each
// Notes: Output delay check waits 12 rises; the shifter has no reset
module odl_checker (
    // Host clock domain
    input wire logic MCLK,
    input wire logic RST,
    // Serial link
    input wire logic serial_clock,
    input wire logic serial_data_in,
    input wire logic load_strobe,
    input wire logic midscale_preset_n,
    input wire logic serial_data_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic sclk_r, sclk_nxt;
    logic [3:0] rise_cnt_r, rise_cnt_nxt;
    logic [3:0] fill_r, fill_nxt;

    // Rises per frame; cleared by the strobe that closes the frame
    always_comb begin
        sclk_nxt = serial_clock;
        rise_cnt_nxt = rise_cnt_r;
        if (load_strobe)
            rise_cnt_nxt = 4'h0;
        else if (serial_clock && !sclk_r)
            rise_cnt_nxt = rise_cnt_r + 4'h1;
    end
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            sclk_r <= 1'b0;
            rise_cnt_r <= 4'h0;
        end else begin
            sclk_r <= sclk_nxt;
            rise_cnt_r <= rise_cnt_nxt;
        end
    end

    // Saturates at 12 so the output compare skips undefined stages
    always_comb fill_nxt = (fill_r == 4'hc) ? fill_r : fill_r + 4'h1;
    always_ff @(posedge serial_clock or posedge RST) begin
        if (RST)
            fill_r <= 4'h0;
        else
            fill_r <= fill_nxt;
    end

    sequence sclk_high_s;
        serial_clock [*4] ##1 !serial_clock;
    endsequence
    sequence strobe_pulse_s;
        load_strobe [*4] ##1 !load_strobe;
    endsequence

    no_rise_strobe_a: assert property (@(posedge MCLK) disable iff (RST)
        load_strobe |-> !serial_clock && !$rose(serial_clock))
        else $error("serial clock high during load strobe");
    preset_release_a: assert property (@(posedge MCLK) disable iff (RST)
        $rose(midscale_preset_n) |-> !load_strobe && !$past(load_strobe))
        else $error("preset released with strobe high");
    preset_quiet_a: assert property (@(posedge MCLK) disable iff (RST)
        !midscale_preset_n |-> !load_strobe && !serial_clock)
        else $error("link active during preset");
    strobe_width_a: assert property (@(posedge MCLK) disable iff (RST)
        $rose(load_strobe) |-> strobe_pulse_s)
        else $error("load strobe width wrong");
    twelve_bits_a: assert property (@(posedge MCLK) disable iff (RST)
        $rose(load_strobe) |-> rise_cnt_r == 4'hc)
        else $error("strobe not after twelve clock rises");
    sclk_high_a: assert property (@(posedge MCLK) disable iff (RST)
        $rose(serial_clock) |-> sclk_high_s)
        else $error("serial clock high half wrong");
    sclk_low_a: assert property (@(posedge MCLK) disable iff (RST)
        $fell(serial_clock) |-> !serial_clock [*4])
        else $error("serial clock low half too short");
    data_stable_a: assert property (@(posedge MCLK) disable iff (RST)
        serial_clock |-> $stable(serial_data_in))
        else $error("serial data changed while clock high");
    sdo_delay_a: assert property (@(posedge serial_clock) disable iff (RST)
        fill_r == 4'hc |-> serial_data_out == $past(serial_data_in, 12))
        else $error("serial data out not twelve clocks late");
endmodule : odl_checker

// [tb/octal_dac_serial_loader_tb_top.sv]
// Purpose: Self-checking bench for host and device ends of the loader
// Assumes: Device channels are preset before any compare
// Notes: Frames are judged in the background as each readback pulses
module octal_dac_serial_loader_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0;
    // Raised just after time zero so every async reset sees an edge
    logic rst = 1'b0;
    logic ce = 1'b1;
    logic word_valid = 1'b0;
    logic preset_req = 1'b0;
    odl_pkg::odl_word_t word_data = 12'h000;
    logic word_ready, busy, rb_valid;
    odl_pkg::odl_word_t rb_word;
    logic [63:0] codes;
    logic [63:0] exp_codes;
    odl_pkg::odl_word_t sent[$];
    int rb_idx = 0;
    int fail_count = 0;
    int tests_run = 0;

    always #2.5 mclk = ~mclk;

    odl_if link ();
    odl_host u_odl_host (.MCLK(mclk), .RST(rst), .CE(ce),
        .WORD_DATA(word_data), .WORD_VALID(word_valid),
        .WORD_READY(word_ready), .PRESET_REQ(preset_req), .BUSY(busy),
        .READBACK_WORD(rb_word), .READBACK_VALID(rb_valid), .link(link));
    odl_dev u_odl_dev (.link(link), .CHANNEL_CODES(codes));
    odl_checker u_odl_checker (.MCLK(mclk), .RST(rst),
        .serial_clock(link.serial_clock),
        .serial_data_in(link.serial_data_in),
        .load_strobe(link.load_strobe),
        .midscale_preset_n(link.midscale_preset_n),
        .serial_data_out(link.serial_data_out));

    task automatic check(input string what, input logic [63:0] e,
                         input logic [63:0] s);
        tests_run++;
        if (s !== e) begin
            $display("unexpected %s: expected %h, seen %h", what, e, s);
            fail_count++;
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    // Readback shows the word held before this frame
    always @(negedge mclk) begin
        if (rb_valid === 1'b1 && rb_idx < sent.size()) begin
            if (sent[rb_idx][11:8] >= 4'h1 && sent[rb_idx][11:8] <= 4'h8)
                exp_codes[(int'(sent[rb_idx][11:8]) - 1) * 8 +: 8] =
                    sent[rb_idx][7:0];
            if (rb_idx > 0)
                check("readback", 64'(sent[rb_idx - 1]), 64'(rb_word));
            check("channel codes", exp_codes, codes);
            rb_idx++;
        end
    end

    task automatic push(input odl_pkg::odl_word_t w);
        int n = 0;
        while (word_ready !== 1'b1 && n < 2000) begin
            @(negedge mclk);
            n++;
        end
        check("word ready", 64'h1, 64'(word_ready));
        sent.push_back(w);
        word_data = w;
        word_valid = 1'b1;
        @(negedge mclk);
        word_valid = 1'b0;
        // One edge with valid low before any following word
        @(negedge mclk);
    endtask : push

    task automatic wait_frames();
        int n = 0;
        while (rb_idx < sent.size() && n < 3000) begin
            @(negedge mclk);
            n++;
        end
        check("frames done", 64'(sent.size()), 64'(rb_idx));
    endtask : wait_frames

    task automatic do_preset();
        int n = 0;
        preset_req = 1'b1;
        repeat (3) @(negedge mclk);
        exp_codes = {8{8'h80}};
        check("preset codes", exp_codes, codes);
        preset_req = 1'b0;
        while (busy !== 1'b0 && n < 50) begin
            @(negedge mclk);
            n++;
        end
        check("busy after preset", 64'h0, 64'(busy));
    endtask : do_preset

    // Every address: eight channels and all no-operation codes
    task automatic addr_sweep();
        for (int a = 0; a < 16; a++) begin
            push({4'(a), 8'(8'h0f + a * 8'h1d)});
            wait_frames();
        end
    endtask : addr_sweep

    // Fill the buffer until it refuses, freeze, then drain
    task automatic burst();
        logic s;
        for (int c = 8; c > 0; c--)
            push({4'(c), 8'(8'hc0 + c)});
        push(12'h0ff);
        @(negedge mclk);
        check("ready when full", 64'h0, 64'(word_ready));
        push(12'h9ff);
        ce = 1'b0;
        s = link.serial_clock;
        repeat (18) @(negedge mclk);
        check("frozen serial clock", 64'(s), 64'(link.serial_clock));
        check("busy while frozen", 64'h1, 64'(busy));
        ce = 1'b1;
        wait_frames();
    endtask : burst

    initial begin
        #1;
        rst = 1'b1;
        repeat (12) @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        do_preset();
        addr_sweep();
        burst();
        do_preset();
        give_verdict();
    end

    initial begin
        #100000;
        $display("unexpected watchdog: expected end of tests, seen hang");
        fail_count++;
        give_verdict();
    end
endmodule : octal_dac_serial_loader_tb_top
